/* File: hdl/ddccf_fmt.sv */
// Output formatter of the coefficient filter: fixed or floating.
// Assumes signed results arriving with a valid strobe.
`timescale 1ns/1ns
module ddccf_fmt import ddccf_pkg::*; (
  // Clock and reset
  input wire logic clk,
  input wire logic arst_n,
  // Mode
  input wire logic [1:0] fmt,
  input wire logic common_exp,
  input wire logic force_scale,
  input wire logic [3:0] scale,
  // Data in
  input wire logic signed [DW-1:0] in_i,
  input wire logic signed [DW-1:0] in_q,
  input wire logic in_valid,
  // Data out
  output logic [OUT_W-1:0] out_i,
  output logic [OUT_W-1:0] out_q,
  output logic out_valid
);
  // Clip rather than wrap
  function automatic logic [OUT_W-1:0] sat(input logic signed [39:0] x, input int w);
    logic signed [39:0] lim;
    lim = (40'sd1 <<< (w - 1)) - 40'sd1;
    if (x > lim) return lim[OUT_W-1:0];
    if (x < -lim - 40'sd1) return 16'((-lim - 40'sd1));
    return x[OUT_W-1:0];
  endfunction : sat

  // Smallest exponent that keeps the mantissa in range
  function automatic logic [3:0] exp_of(input logic signed [39:0] x, input int w);
    logic [3:0] e;
    logic signed [39:0] lim;
    e = 4'hf;
    lim = (40'sd1 <<< (w - 1)) - 40'sd1;
    for (int k = 15; k >= 0; k--) begin
      if (((x >>> k) <= lim) && ((x >>> k) >= -lim - 40'sd1)) e = 4'(k);
    end
    return e;
  endfunction : exp_of

  logic signed [39:0] wi;
  logic signed [39:0] wq;
  int mw;
  logic [3:0] ei;
  logic [3:0] eq;
  logic [3:0] emax;
  logic [OUT_W-1:0] mi12;
  logic [OUT_W-1:0] mq12;
  logic [OUT_W-1:0] mi8;
  logic [OUT_W-1:0] mq8;

  always_comb begin
    wi = 40'(in_i);
    wq = 40'(in_q);
    mw = fmt[1] ? MANT_W12 : MANT_W8;
    ei = force_scale ? scale : exp_of(wi, mw);
    eq = force_scale ? scale : exp_of(wq, mw);
    emax = (ei > eq) ? ei : eq;
    if (common_exp && !force_scale) begin
      ei = emax;
      eq = emax;
    end
    // Clipped mantissas, cut to width in the register below
    mi12 = sat(wi >>> ei, MANT_W12);
    mq12 = sat(wq >>> eq, MANT_W12);
    mi8 = sat(wi >>> ei, MANT_W8);
    mq8 = sat(wq >>> eq, MANT_W8);
  end

  // ==========================================================
  // Formatting register
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      out_i <= 16'h0000;
      out_q <= 16'h0000;
      out_valid <= 1'b0;
    end else begin
      out_valid <= in_valid;
      if (in_valid) begin
        if (fmt == FMT_FIXED) begin
          // Gain of (scale - 3) x 6.02 dB
          out_i <= sat((wi <<< scale) >>> FIX_SCALE_BIAS, OUT_W);
          out_q <= sat((wq <<< scale) >>> FIX_SCALE_BIAS, OUT_W);
        end else if (fmt[1]) begin
          out_i <= {ei, mi12[MANT_W12-1:0]};
          out_q <= {eq, mq12[MANT_W12-1:0]};
        end else begin
          out_i <= {ei, mi8[MANT_W8-1:0], 4'h0};
          out_q <= {eq, mq8[MANT_W8-1:0], 4'h0};
        end
      end
    end
  end
endmodule : ddccf_fmt

/* File: hdl/ddccf_phase.sv */
// Oscillator phase accumulator with offset and hop clearing.
// Assumes hop is a one-cycle pulse from the sync control logic.
`timescale 1ns/1ns
module ddccf_phase import ddccf_pkg::*; (
  // Clock and reset
  input wire logic clk,
  input wire logic arst_n,
  // Control
  input wire logic [31:0] freq_word,
  input wire logic [15:0] phase_ofs,
  input wire logic hop,
  input wire logic hop_clear,
  // Result
  output logic [15:0] phase_out
);
  logic [31:0] acc_r;

  // ==========================================================
  // Accumulator
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      acc_r <= 32'h00000000;
    end else if (hop && hop_clear) begin
      acc_r <= 32'h00000000;
    end else begin
      acc_r <= acc_r + freq_word;
    end
  end

  // ==========================================================
  // Final phase, wraps modulo one turn
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      phase_out <= 16'h0000;
    end else begin
      phase_out <= acc_r[31:16] + phase_ofs;
    end
  end
endmodule : ddccf_phase

/* File: hdl/ddccf_pkg.sv */
// Constants for the channel filter configuration bank.
// Assumes one channel clock and 8-bit channel addresses.
package ddccf_pkg;
  // ==========================================================
  // Channel register offsets
  localparam logic [7:0] OFS_PHASE = 8'h87;
  localparam logic [7:0] OFS_OSC_CTRL = 8'h88;
  localparam logic [7:0] OFS_RS_DEC = 8'h90;
  localparam logic [7:0] OFS_RS_INTERP = 8'h91;
  localparam logic [7:0] OFS_RS_SCALE = 8'h92;
  localparam logic [7:0] OFS_RSVD_A = 8'h93;
  localparam logic [7:0] OFS_C5_DEC = 8'h94;
  localparam logic [7:0] OFS_C5_SCALE = 8'h95;
  localparam logic [7:0] OFS_RSVD_B = 8'h96;
  localparam logic [7:0] OFS_CF_DEC = 8'ha0;
  localparam logic [7:0] OFS_CF_PHASE = 8'ha1;
  localparam logic [7:0] OFS_CF_TAPS = 8'ha2;
  localparam logic [7:0] OFS_CF_COEF = 8'ha3;
  localparam logic [7:0] OFS_CF_CTRL = 8'ha4;
  localparam logic [7:0] OFS_ST_I = 8'ha5;
  localparam logic [7:0] OFS_ST_Q = 8'ha6;
  // ==========================================================
  // Widths
  localparam int ADDR_W = 8;
  localparam int WDATA_W = 20;
  localparam int RDATA_W = 16;
  localparam int ADC_W = 16;
  localparam int DW = 24;
  localparam int NCH = 4;
  // ==========================================================
  // Field positions
  localparam int OC_SYNC_LO = 7;
  localparam int OC_INSEL = 6;
  localparam int OC_HOPCLR = 3;
  localparam int OC_ADITH = 2;
  localparam int OC_PDITH = 1;
  localparam int OC_BYPASS = 0;
  localparam int RS_QUIET_LO = 5;
  localparam int RS_LOUD_LO = 0;
  localparam int CF_STBYP = 10;
  localparam int CF_SRC = 9;
  localparam int CF_BANK = 8;
  localparam int CF_COMMON = 7;
  localparam int CF_FORCE = 6;
  localparam int CF_FMT_LO = 4;
  localparam int CF_SCALE_LO = 0;
  localparam int COEF_BANK_BIT = 7;
  // ==========================================================
  // Masks, reset values, format codes
  localparam logic [8:0] OSC_CTRL_MASK = 9'h1cf;
  localparam logic [11:0] RS_SCALE_MASK = 12'h3ff;
  localparam logic [19:0] RST_VAL = 20'h00000;
  localparam logic [1:0] FMT_FIXED = 2'h0;
  localparam logic [1:0] FMT_F8 = 2'h1;
  localparam logic [3:0] FIX_SCALE_BIAS = 4'h3;
  localparam int MANT_W12 = 12;
  localparam int MANT_W8 = 8;
  localparam int OUT_W = 16;

  // Partner channel whose comb output feeds this filter
  function automatic int ddccf_partner(input int ch);
    return (ch == 1) ? 0 : 1;
  endfunction : ddccf_partner
endpackage : ddccf_pkg

/* File: hdl/ddccf_top.sv */
// Channel filter configuration bank of one downconverter channel.
// Assumes the channel register port and data strobes are synchronous
// to clk; sync controls and output control live outside this block.
`timescale 1ns/1ns
module ddccf_top import ddccf_pkg::*; #(
  parameter int CHANNEL = 0
) (
  // Clock and reset
  input wire logic clk,
  input wire logic arst_n,
  // Channel register port
  input wire logic [ADDR_W-1:0] chan_addr,
  input wire logic wr_en,
  input wire logic [WDATA_W-1:0] wr_data,
  input wire logic rd_en,
  output logic [RDATA_W-1:0] rd_data,
  // Coefficient memory write
  output logic coef_wr_en,
  output logic [ADDR_W-1:0] coef_wr_addr,
  output logic [WDATA_W-1:0] coef_wr_data,
  // Sync and oscillator
  input wire logic [3:0] sync_pins,
  input wire logic hop,
  input wire logic [31:0] freq_word,
  output logic chan_sync,
  output logic [15:0] osc_phase,
  output logic amp_dither_en,
  output logic phase_dither_en,
  // Converter inputs
  input wire logic [ADC_W-1:0] in_a,
  input wire logic [ADC_W-1:0] in_b,
  output logic [ADC_W-1:0] mix_in,
  output logic [ADC_W-1:0] path_i,
  output logic [ADC_W-1:0] path_q,
  output logic osc_bypass,
  // Resampler and comb5
  input wire logic level_indicator,
  output logic [11:0] resampler_decimation,
  output logic [8:0] resampler_interpolation,
  output logic [4:0] resampler_scale,
  output logic [7:0] comb5_decimation,
  output logic [4:0] comb5_scale,
  // Coefficient filter
  input wire logic [NCH*DW-1:0] comb_i_all,
  input wire logic [NCH*DW-1:0] comb_q_all,
  input wire logic comb_valid,
  input wire logic filter_start,
  input wire logic filter_out_stb,
  input wire logic map_to_self_test,
  output logic [7:0] filter_decimation,
  output logic [7:0] filter_taps,
  output logic [7:0] filter_decimation_phase,
  output logic [7:0] filter_coefficient_offset,
  output logic [DW-1:0] filter_in_i,
  output logic [DW-1:0] filter_in_q,
  output logic filter_bypass,
  // Formatter
  input wire logic [DW-1:0] filter_res_i,
  input wire logic [DW-1:0] filter_res_q,
  input wire logic filter_res_valid,
  output logic [OUT_W-1:0] fmt_out_i,
  output logic [OUT_W-1:0] fmt_out_q,
  output logic fmt_valid,
  // Self-test signatures
  output logic [15:0] self_test_signature_i,
  output logic [15:0] self_test_signature_q
);
  localparam int PARTNER = ddccf_partner(CHANNEL);

  function automatic logic hit(input logic en, input logic [7:0] a, input logic [7:0] o);
    return en && (a == o);
  endfunction : hit

  // ==========================================================
  // Configuration registers
  logic [15:0] phase_ofs_r;
  logic [8:0] osc_ctrl_r;
  logic [11:0] rs_dec_r;
  logic [8:0] rs_interp_r;
  logic [11:0] rs_scale_r;
  logic [7:0] c5_dec_r;
  logic [4:0] c5_scale_r;
  logic [7:0] cf_dec_r;
  logic [7:0] cf_phase_r;
  logic [7:0] cf_taps_r;
  logic [7:0] cf_coef_r;
  logic [10:0] cf_ctrl_r;

  // Reserved offsets hold no storage; writes to them are dropped
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      phase_ofs_r <= RST_VAL[15:0];
      osc_ctrl_r <= RST_VAL[8:0];
      rs_dec_r <= RST_VAL[11:0];
      rs_interp_r <= RST_VAL[8:0];
      rs_scale_r <= RST_VAL[11:0];
      c5_dec_r <= RST_VAL[7:0];
      c5_scale_r <= RST_VAL[4:0];
      cf_dec_r <= RST_VAL[7:0];
      cf_phase_r <= RST_VAL[7:0];
      cf_taps_r <= RST_VAL[7:0];
      cf_coef_r <= RST_VAL[7:0];
      cf_ctrl_r <= RST_VAL[10:0];
    end else begin
      if (hit(wr_en, chan_addr, OFS_PHASE)) phase_ofs_r <= wr_data[15:0];
      // Reserved bits masked so a careless write cannot leak
      if (hit(wr_en, chan_addr, OFS_OSC_CTRL)) osc_ctrl_r <= wr_data[8:0] & OSC_CTRL_MASK;
      if (hit(wr_en, chan_addr, OFS_RS_DEC)) rs_dec_r <= wr_data[11:0];
      if (hit(wr_en, chan_addr, OFS_RS_INTERP)) rs_interp_r <= wr_data[8:0];
      if (hit(wr_en, chan_addr, OFS_RS_SCALE)) rs_scale_r <= wr_data[11:0] & RS_SCALE_MASK;
      if (hit(wr_en, chan_addr, OFS_C5_DEC)) c5_dec_r <= wr_data[7:0];
      if (hit(wr_en, chan_addr, OFS_C5_SCALE)) c5_scale_r <= wr_data[4:0];
      if (hit(wr_en, chan_addr, OFS_CF_DEC)) cf_dec_r <= wr_data[7:0];
      if (hit(wr_en, chan_addr, OFS_CF_PHASE)) cf_phase_r <= wr_data[7:0];
      if (hit(wr_en, chan_addr, OFS_CF_TAPS)) cf_taps_r <= wr_data[7:0];
      if (hit(wr_en, chan_addr, OFS_CF_COEF)) cf_coef_r <= wr_data[7:0];
      if (hit(wr_en, chan_addr, OFS_CF_CTRL)) cf_ctrl_r <= wr_data[10:0];
    end
  end

  // Counts pass through as minus-one codes; the filters add one
  assign resampler_decimation = rs_dec_r;
  assign resampler_interpolation = rs_interp_r;
  assign comb5_decimation = c5_dec_r;
  assign comb5_scale = c5_scale_r;
  assign filter_decimation = cf_dec_r;
  assign filter_taps = cf_taps_r;
  assign amp_dither_en = osc_ctrl_r[OC_ADITH];
  assign phase_dither_en = osc_ctrl_r[OC_PDITH];
  assign osc_bypass = osc_ctrl_r[OC_BYPASS];
  assign filter_bypass = cf_ctrl_r[CF_STBYP];

  // ==========================================================
  // Coefficient memory write path
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      coef_wr_en <= 1'b0;
      coef_wr_addr <= RST_VAL[7:0];
      coef_wr_data <= RST_VAL;
    end else begin
      coef_wr_en <= wr_en && !chan_addr[COEF_BANK_BIT];
      coef_wr_addr <= {cf_ctrl_r[CF_BANK], chan_addr[6:0]};
      coef_wr_data <= wr_data;
    end
  end

  // ==========================================================
  // Oscillator and input routing
  ddccf_phase u_phase (
    .clk(clk),
    .arst_n(arst_n),
    .freq_word(freq_word),
    .phase_ofs(phase_ofs_r),
    .hop(hop),
    .hop_clear(osc_ctrl_r[OC_HOPCLR]),
    .phase_out(osc_phase)
  );

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      chan_sync <= 1'b0;
      mix_in <= RST_VAL[15:0];
      path_i <= RST_VAL[15:0];
      path_q <= RST_VAL[15:0];
      resampler_scale <= RST_VAL[4:0];
    end else begin
      chan_sync <= sync_pins[osc_ctrl_r[OC_SYNC_LO +: 2]];
      mix_in <= osc_ctrl_r[OC_INSEL] ? in_b : in_a;
      // Translation stage skipped: raw ports straight to I and Q
      path_i <= osc_ctrl_r[OC_BYPASS] ? in_a : RST_VAL[15:0];
      path_q <= osc_ctrl_r[OC_BYPASS] ? in_b : RST_VAL[15:0];
      resampler_scale <= level_indicator ? rs_scale_r[RS_QUIET_LO +: 5]
                                         : rs_scale_r[RS_LOUD_LO +: 5];
    end
  end

  // ==========================================================
  // Working phase and coefficient pointer
  // Shadow keeps a mid-filter write from corrupting the current output
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      filter_decimation_phase <= RST_VAL[7:0];
      filter_coefficient_offset <= RST_VAL[7:0];
    end else begin
      if (filter_start) filter_decimation_phase <= cf_phase_r;
      if (filter_out_stb) filter_coefficient_offset <= cf_coef_r;
    end
  end

  // ==========================================================
  // Filter input source
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      filter_in_i <= RST_VAL[DW-1:0];
      filter_in_q <= RST_VAL[DW-1:0];
    end else if (comb_valid) begin
      if (cf_ctrl_r[CF_SRC]) begin
        filter_in_i <= comb_i_all[PARTNER*DW +: DW];
        filter_in_q <= comb_q_all[PARTNER*DW +: DW];
      end else begin
        filter_in_i <= comb_i_all[CHANNEL*DW +: DW];
        filter_in_q <= comb_q_all[CHANNEL*DW +: DW];
      end
    end
  end

  // ==========================================================
  // Output formatting
  ddccf_fmt u_fmt (
    .clk(clk),
    .arst_n(arst_n),
    .fmt(cf_ctrl_r[CF_FMT_LO +: 2]),
    .common_exp(cf_ctrl_r[CF_COMMON]),
    .force_scale(cf_ctrl_r[CF_FORCE]),
    .scale(cf_ctrl_r[CF_SCALE_LO +: 4]),
    .in_i(filter_res_i),
    .in_q(filter_res_q),
    .in_valid(filter_res_valid),
    .out_i(fmt_out_i),
    .out_q(fmt_out_q),
    .out_valid(fmt_valid)
  );

  // ==========================================================
  // Self-test capture
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      self_test_signature_i <= RST_VAL[15:0];
      self_test_signature_q <= RST_VAL[15:0];
    end else if (cf_ctrl_r[CF_STBYP]) begin
      if (comb_valid) begin
        self_test_signature_i <= comb_i_all[CHANNEL*DW+DW-16 +: 16];
        self_test_signature_q <= comb_q_all[CHANNEL*DW+DW-16 +: 16];
      end
    end else if (fmt_valid) begin
      self_test_signature_i <= fmt_out_i;
      self_test_signature_q <= fmt_out_q;
    end
  end

  // ==========================================================
  // Register read-back
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      rd_data <= RST_VAL[15:0];
    end else if (rd_en) begin
      case (chan_addr)
        OFS_PHASE: rd_data <= phase_ofs_r;
        OFS_OSC_CTRL: rd_data <= 16'(osc_ctrl_r);
        OFS_RS_DEC: rd_data <= 16'(rs_dec_r);
        OFS_RS_INTERP: rd_data <= 16'(rs_interp_r);
        OFS_RS_SCALE: rd_data <= 16'(rs_scale_r);
        OFS_C5_DEC: rd_data <= 16'(c5_dec_r);
        OFS_C5_SCALE: rd_data <= 16'(c5_scale_r);
        OFS_CF_DEC: rd_data <= 16'(cf_dec_r);
        OFS_CF_PHASE: rd_data <= 16'(cf_phase_r);
        OFS_CF_TAPS: rd_data <= 16'(cf_taps_r);
        OFS_CF_COEF: rd_data <= 16'(cf_coef_r);
        OFS_CF_CTRL: rd_data <= 16'(cf_ctrl_r);
        OFS_ST_I: rd_data <= map_to_self_test ? self_test_signature_i : 16'h0000;
        OFS_ST_Q: rd_data <= map_to_self_test ? self_test_signature_q : 16'h0000;
        default: rd_data <= 16'h0000;
      endcase
    end
  end

  // ==========================================================
  // Checks
  a_sync_select: assert property (@(posedge clk) disable iff (!arst_n)
    1'b1 |=> chan_sync == $past(sync_pins[osc_ctrl_r[OC_SYNC_LO +: 2]]))
    else $error("sync pin select wrong");

  a_input_route: assert property (@(posedge clk) disable iff (!arst_n)
    osc_ctrl_r[OC_INSEL] && $stable(osc_ctrl_r) |=> mix_in == $past(in_b))
    else $error("input port B not routed");

  a_bypass_path: assert property (@(posedge clk) disable iff (!arst_n)
    osc_ctrl_r[OC_BYPASS] |=> path_i == $past(in_a) && path_q == $past(in_b))
    else $error("bypass routing wrong");

  a_hop_clear: assert property (@(posedge clk) disable iff (!arst_n)
    hop && osc_ctrl_r[OC_HOPCLR] && $stable(phase_ofs_r)
    |=> ##1 osc_phase == $past(phase_ofs_r))
    else $error("hop did not clear accumulator");

  a_dither_en: assert property (@(posedge clk) disable iff (!arst_n)
    hit(wr_en, chan_addr, OFS_OSC_CTRL)
    |=> amp_dither_en == $past(wr_data[OC_ADITH]) && phase_dither_en == $past(wr_data[OC_PDITH]))
    else $error("dither enable not taken");

  a_scale_pick: assert property (@(posedge clk) disable iff (!arst_n)
    level_indicator && $stable(rs_scale_r)
    |=> resampler_scale == $past(rs_scale_r[RS_QUIET_LO +: 5]))
    else $error("resampler scale choice wrong");

  a_phase_hold: assert property (@(posedge clk) disable iff (!arst_n)
    !filter_start |=> $stable(filter_decimation_phase))
    else $error("decimation phase changed outside start");

  a_phase_load: assert property (@(posedge clk) disable iff (!arst_n)
    filter_start |=> filter_decimation_phase == $past(cf_phase_r))
    else $error("decimation phase not reloaded");

  a_coef_shadow: assert property (@(posedge clk) disable iff (!arst_n)
    !filter_out_stb |=> $stable(filter_coefficient_offset))
    else $error("coefficient pointer moved early");

  a_coef_bank: assert property (@(posedge clk) disable iff (!arst_n)
    wr_en && !chan_addr[COEF_BANK_BIT]
    |=> coef_wr_en && coef_wr_addr[7] == $past(cf_ctrl_r[CF_BANK]))
    else $error("coefficient bank wrong");

  a_src_select: assert property (@(posedge clk) disable iff (!arst_n)
    comb_valid && cf_ctrl_r[CF_SRC] |=> filter_in_i == $past(comb_i_all[PARTNER*DW +: DW]))
    else $error("partner comb not selected");
endmodule : ddccf_top

/* File: test/ddccf_top_tb.sv */
// Self-checking bench for the channel filter configuration bank.
// Assumes ddccf_top under hdl/, instance built as channel 2.
`timescale 1ns/1ns
module ddccf_top_tb import ddccf_pkg::*; ;
  // ==========================================================
  // Signals
  logic clk, arst_n, wr_en, rd_en, hop, level_indicator, comb_valid, filter_start;
  logic filter_out_stb, map_to_self_test, filter_res_valid, rd_seen;
  logic [7:0] chan_addr;
  logic [19:0] wr_data;
  logic [3:0] sync_pins;
  logic [31:0] freq_word;
  logic [15:0] in_a, in_b, rd_data, osc_phase, mix_in, path_i, path_q;
  logic [95:0] comb_i_all, comb_q_all;
  logic [23:0] filter_res_i, filter_res_q, filter_in_i, filter_in_q;
  logic coef_wr_en, chan_sync, amp_dither_en, phase_dither_en, osc_bypass, filter_bypass;
  logic fmt_valid;
  logic [7:0] coef_wr_addr, comb5_decimation, filter_decimation, filter_taps;
  logic [7:0] filter_decimation_phase, filter_coefficient_offset;
  logic [19:0] coef_wr_data;
  logic [11:0] resampler_decimation;
  logic [8:0] resampler_interpolation, oc;
  logic [4:0] resampler_scale, comb5_scale;
  logic [15:0] fmt_out_i, fmt_out_q, self_test_signature_i, self_test_signature_q;
  logic [19:0] wv [16];
  logic [15:0] exp_q [$];
  int errors, total_checks, cyc;
  localparam logic [7:0] ADR [16] = '{8'h87, 8'h88, 8'h89, 8'h90, 8'h91, 8'h92, 8'h93,
    8'h94, 8'h95, 8'h96, 8'h97, 8'ha0, 8'ha1, 8'ha2, 8'ha3, 8'ha4};
  localparam logic [15:0] MSK [16] = '{16'hffff, 16'h01cf, 16'h0, 16'h0fff, 16'h01ff,
    16'h03ff, 16'h0, 16'h00ff, 16'h001f, 16'h0, 16'h0, 16'h00ff, 16'h00ff, 16'h00ff,
    16'h00ff, 16'h07ff};
  localparam logic [10:0] CTL [7] = '{11'h003, 11'h013, 11'h023, 11'h033, 11'h004,
    11'h062, 11'h090};
  localparam logic [15:0] FEX [7] = '{16'h0005, 16'h0050, 16'h0005, 16'h0005, 16'h000a,
    16'h2001, 16'h4000};
  localparam logic [15:0] FEQ [7] = '{16'h0400, 16'h4400, 16'h0400, 16'h0400, 16'h0800,
    16'h2100, 16'h4400};

  ddccf_top #(.CHANNEL(2)) u_dut (.clk, .arst_n, .chan_addr, .wr_en, .wr_data, .rd_en,
    .rd_data, .coef_wr_en, .coef_wr_addr, .coef_wr_data, .sync_pins, .hop, .freq_word,
    .chan_sync, .osc_phase, .amp_dither_en, .phase_dither_en, .in_a, .in_b, .mix_in,
    .path_i, .path_q, .osc_bypass, .level_indicator, .resampler_decimation,
    .resampler_interpolation, .resampler_scale, .comb5_decimation, .comb5_scale,
    .comb_i_all, .comb_q_all, .comb_valid, .filter_start, .filter_out_stb,
    .map_to_self_test, .filter_decimation, .filter_taps, .filter_decimation_phase,
    .filter_coefficient_offset, .filter_in_i, .filter_in_q, .filter_bypass, .filter_res_i,
    .filter_res_q, .filter_res_valid, .fmt_out_i, .fmt_out_q, .fmt_valid,
    .self_test_signature_i, .self_test_signature_q);

  // ==========================================================
  // Tasks
  task automatic final_report;
    if (errors == 0 && total_checks > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask : final_report

  task automatic chk(input logic [23:0] s, input logic [23:0] e, input string n);
    total_checks++;
    if (s !== e) begin
      errors++;
      $display("[ERR] %s expected %h seen %h", n, e, s);
    end
  endtask : chk

  task automatic tick;
    @(posedge clk);
    #1;
  endtask : tick

  // Strobes stay up between accesses so back-to-back never lowers and raises at once
  task automatic wr(input logic [7:0] a, input logic [19:0] d);
    chan_addr = a;
    wr_data = d;
    rd_en = 1'b0;
    wr_en = 1'b1;
    tick();
  endtask : wr

  task automatic rd(input logic [7:0] a, input logic [15:0] e);
    chan_addr = a;
    wr_en = 1'b0;
    rd_en = 1'b1;
    exp_q.push_back(e);
    tick();
  endtask : rd

  task automatic idle;
    wr_en = 1'b0;
    rd_en = 1'b0;
    tick();
  endtask : idle

  // ==========================================================
  // Clock, read monitor, timeout
  initial begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end

  always @(posedge clk) begin
    if (rd_seen) chk(rd_data, exp_q.pop_front(), "rd_data");
    rd_seen <= rd_en;
  end

  // Whole run is well under 1000 cycles
  always @(posedge clk) begin
    cyc++;
    if (cyc == 3000) begin
      errors++;
      final_report();
    end
  end

  // ==========================================================
  // Stimulus
  initial begin
    {arst_n, wr_en, rd_en, hop, level_indicator, comb_valid, filter_start, rd_seen} = '0;
    {filter_out_stb, map_to_self_test, filter_res_valid, chan_addr, wr_data} = '0;
    {sync_pins, freq_word, in_a, in_b, comb_i_all, comb_q_all} = '0;
    {filter_res_i, filter_res_q} = '0;
    void'($urandom(32'h9e8573dc));
    repeat (2) @(posedge clk);
    #1;
    arst_n = 1'b1;
    foreach (ADR[i]) rd(ADR[i], 16'h0);
    foreach (ADR[i]) begin
      wv[i] = 20'($urandom) & 20'(MSK[i]);
      // Decimation kept above any interpolation code
      if (i == 3) wv[i][11] = 1'b1;
      wr(ADR[i], wv[i]);
    end
    foreach (ADR[i]) rd(ADR[i], wv[i][15:0] & MSK[i]);
    idle();
    chk(resampler_decimation, wv[3][11:0], "rs_dec");
    chk(resampler_interpolation, wv[4][8:0], "rs_int");
    chk(comb5_decimation, wv[7][7:0], "c5_dec");
    chk(comb5_scale, wv[8][4:0], "c5_scale");
    chk(filter_decimation, wv[11][7:0], "cf_dec");
    chk(filter_taps, wv[13][7:0], "cf_taps");
    // Working copies must wait for their load strobes
    chk(filter_decimation_phase, 24'h0, "cf_phase");
    chk(filter_coefficient_offset, 24'h0, "cf_coef");
    filter_start = 1'b1;
    filter_out_stb = 1'b1;
    tick();
    {filter_start, filter_out_stb} = '0;
    chk(filter_decimation_phase, wv[12][7:0], "cf_phase");
    chk(filter_coefficient_offset, wv[14][7:0], "cf_coef");
    for (int l = 0; l < 2; l++) begin
      level_indicator = l[0];
      repeat (2) tick();
      chk(resampler_scale, l[0] ? wv[5][9:5] : wv[5][4:0], "rs_scale");
    end
    for (int s = 0; s < 4; s++) begin
      oc = {s[1:0], s[0], 3'h0, s[1], s[0], s[1]};
      wr(8'h88, {11'h0, oc});
      sync_pins = 4'h1 << s;
      in_a = 16'($urandom);
      in_b = 16'($urandom);
      repeat (2) idle();
      chk(chan_sync, 24'h1, "chan_sync");
      chk(amp_dither_en, s[1], "amp_dith");
      chk(phase_dither_en, s[0], "ph_dith");
      chk(mix_in, s[0] ? in_b : in_a, "mix_in");
      chk(path_i, s[1] ? in_a : 16'h0, "path_i");
      chk(path_q, s[1] ? in_b : 16'h0, "path_q");
      chk(osc_bypass, s[1], "bypass");
      sync_pins = ~sync_pins;
      repeat (2) tick();
      chk(chan_sync, 24'h0, "chan_sync");
    end
    // Accumulator runs first so the clear is visible
    freq_word = $urandom;
    wr(8'h87, wv[0]);
    wr(8'h88, 20'h00008);
    hop = 1'b1;
    idle();
    hop = 1'b0;
    idle();
    chk(osc_phase, wv[0][15:0], "osc_phase");
    for (int b = 0; b < 2; b++) begin
      wr(8'ha4, {11'h0, b[0], 8'h0});
      wv[b + 1] = 20'($urandom);
      wr(8'h15, wv[b + 1]);
      chk(coef_wr_en, 24'h1, "coef_en");
      chk(coef_wr_addr, {b[0], 7'h15}, "coef_addr");
      chk(coef_wr_data, wv[b + 1], "coef_data");
      wr(8'ha4, {10'h0, b[0], 9'h0});
      comb_i_all = {$urandom, $urandom, $urandom};
      comb_q_all = {$urandom, $urandom, $urandom};
      comb_valid = 1'b1;
      idle();
      comb_valid = 1'b0;
      chk(filter_in_i, comb_i_all[(b ? 24 : 48) +: 24], "cf_in_i");
      chk(filter_in_q, comb_q_all[(b ? 24 : 48) +: 24], "cf_in_q");
    end
    wr(8'ha4, 20'h00400);
    map_to_self_test = 1'b1;
    comb_valid = 1'b1;
    idle();
    comb_valid = 1'b0;
    idle();
    chk(filter_bypass, 24'h1, "cf_bypass");
    chk(self_test_signature_i, comb_i_all[71:56], "st_i");
    rd(8'ha5, comb_i_all[71:56]);
    rd(8'ha6, comb_q_all[71:56]);
    map_to_self_test = 1'b0;
    rd(8'ha5, 16'h0);
    foreach (CTL[k]) begin
      wr(8'ha4, {9'h0, CTL[k]});
      filter_res_i = 24'h000005;
      filter_res_q = 24'h000400;
      filter_res_valid = 1'b1;
      idle();
      filter_res_valid = 1'b0;
      chk(fmt_valid, 24'h1, "fmt_valid");
      chk(fmt_out_i, FEX[k], "fmt_out_i");
      chk(fmt_out_q, FEQ[k], "fmt_out_q");
    end
    repeat (3) idle();
    final_report();
  end
endmodule : ddccf_top_tb
